// ### terminal_serial_link_dataflow_test.sv
`timescale 1ns/1ps
module terminal_serial_link_dataflow_test;
   import tslk_pkg::*;
   localparam int CLK_HZ = 48000;   // ten clocks per bit at the top rate
   localparam int MEMD   = 4;

   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic              line_rxd, line_txd, kbd_valid, kbd_ready, dsp_tx_valid, dsp_tx_ready;
   logic              dsp_rx_valid, dsp_rx_ready, mem_rd, cursor_bottom_only, l, o;
   logic [6:0]        kbd_char, dsp_tx_char, dsp_rx_char, mem_data, c;
   logic [1:0]        mem_addr;
   logic [6:0]        memv[MEMD];
   logic [6:0]        exp_dsp[$];
   logic [7:0]        exp_line[$];
   int                fail_count = 0;
   int                cmp_count = 0;

   always #12.5 clk = ~clk;
   assign hready = hreadyout;

   tslk_link #(.CLK_HZ(CLK_HZ), .MEM_DEPTH(MEMD)) uut (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .line_rxd(line_rxd), .line_txd(line_txd), .kbd_char(kbd_char),
      .kbd_valid(kbd_valid), .kbd_ready(kbd_ready), .dsp_tx_char(dsp_tx_char),
      .dsp_tx_valid(dsp_tx_valid), .dsp_tx_ready(dsp_tx_ready), .dsp_rx_char(dsp_rx_char),
      .dsp_rx_valid(dsp_rx_valid), .dsp_rx_ready(dsp_rx_ready), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_data(mem_data), .cursor_bottom_only(cursor_bottom_only));
   tslk_host host (.line_txd(line_txd), .line_rxd(line_rxd));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic bad, input string m);
      cmp_count++;
      if (bad !== 1'b0) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk

   task conclude();
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   function automatic logic [31:0] cfg(input logic h, input logic [1:0] m, input logic lg,
                                       input logic od, input logic [3:0] b);
      return {23'h0, b, od, lg, m, h};
   endfunction : cfg

   // single transfer; read data lands in rd
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk(hresp, "hresp");
   endtask : ahb

   // ready is combinational, so it is judged mid-cycle
   task automatic src(input bit dsp, input logic [6:0] ch);
      if (dsp) begin
         dsp_tx_char <= ch;
         dsp_tx_valid <= 1'b1;
      end else begin
         kbd_char <= ch;
         kbd_valid <= 1'b1;
      end
      do @(negedge clk); while ((dsp ? dsp_tx_ready : kbd_ready) !== 1'b1);
      @(posedge clk);
      dsp_tx_valid <= 1'b0;
      kbd_valid <= 1'b0;
   endtask : src

   task automatic wline();
      int n = 0;
      while (host.rxq.size() < exp_line.size() && n++ < 40000) @(posedge clk);
      chk(host.rxq.size() != exp_line.size(), "line char count");
      while (host.rxq.size() > 0 && exp_line.size() > 0)
         chk(host.rxq.pop_front() !== exp_line.pop_front(), "line char");
      host.rxq.delete();
      exp_line.delete();
   endtask : wline

   task automatic wdsp();
      int n = 0;
      while (exp_dsp.size() > 0 && n++ < 40000) @(posedge clk);
      chk(exp_dsp.size() != 0, "display char missing");
      exp_dsp.delete();
   endtask : wdsp

   ////////////////////////////////////////////////////////////////////////////////
   // display sink: both high means taken at the next edge
   always @(negedge clk) begin
      if (rst_n && dsp_rx_valid === 1'b1 && dsp_rx_ready === 1'b1) begin
         if (exp_dsp.size() == 0) chk(1'b1, "unexpected display char");
         else chk(dsp_rx_char !== exp_dsp.pop_front(), "display char");
      end
   end

   // memory answers after the read strobe; sink stalls at random
   always @(posedge clk) if (mem_rd === 1'b1) mem_data <= memv[mem_addr];
   always @(posedge clk) dsp_rx_ready <= ($urandom % 4) != 0;

   // hang guard, about four times the expected run
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      {hsel, hwrite, haddr, hwdata, htrans, kbd_valid, dsp_tx_valid} = '0;
      {kbd_char, dsp_tx_char, mem_data} = '0;
      hsize = 3'h2;
      dsp_rx_ready = 1'b1;
      void'($urandom(32'hc175));
      foreach (memv[i]) memv[i] = 7'($urandom);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      ahb(1'b0, 32'(OFS_CTRL), 32'h0);
      chk(rd[8:0] !== CTRL_RESET, "control reset value");
      ahb(1'b0, 32'h10, 32'h0);
      chk(rd !== 32'h0, "unmapped read");
      // every rate, random format, page and roll alternating
      for (int s = 0; s < 9; s++) begin
         l = 1'($urandom);
         o = 1'($urandom);
         host.long_f = l;
         host.odd_f = o;
         host.bit_ns = (CLK_HZ / BAUD_TABLE[s]) * 25;
         ahb(1'b1, 32'(OFS_CTRL), cfg(1'b0, (s % 2) ? MODE_ROLL : MODE_PAGE, l, o, 4'(s)));
         c = 7'($urandom);
         exp_line.push_back({1'b0, c});
         src(1'b0, c);
         wline();
         chk(cursor_bottom_only !== (s % 2 == 1), "cursor confinement");
         c = 7'($urandom);
         exp_dsp.push_back(c);
         host.send(c, 1'b0);
         wdsp();
      end
      // half duplex: display source goes out and loops back
      host.long_f = 1'b0;
      host.odd_f = 1'b0;
      ahb(1'b1, 32'(OFS_CTRL), cfg(1'b1, MODE_PAGE, 1'b0, 1'b0, 4'h8));
      c = 7'($urandom);
      exp_line.push_back({1'b0, c});
      exp_dsp.push_back(c);
      src(1'b1, c);
      wline();
      wdsp();
      // page-buffered: keystroke stays local, parity ignored for display
      ahb(1'b1, 32'(OFS_CTRL), cfg(1'b0, MODE_PBUF, 1'b0, 1'b0, 4'h8));
      c = 7'($urandom);
      exp_dsp.push_back(c);
      src(1'b0, c);
      wdsp();
      c = 7'($urandom);
      exp_dsp.push_back(c);
      host.send(c, 1'b1);
      wdsp();
      wline();
      ahb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk(rd[ST_PERR_BIT] !== 1'b1, "parity flag not set");
      ahb(1'b1, 32'(OFS_STATUS), 32'h10);
      ahb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk(rd[ST_PERR_BIT] !== 1'b0, "parity flag not cleared");
      // send command streams memory in order
      foreach (memv[i]) exp_line.push_back({1'b0, memv[i]});
      ahb(1'b1, 32'(OFS_CMD), 32'h1);
      wline();
      conclude();
   end
endmodule : terminal_serial_link_dataflow_test

// ### tslk_host.sv
`timescale 1ns/1ps
module tslk_host (
   // serial line seen from the computer
   input  wire logic line_txd,
   output logic      line_rxd
);
   logic       long_f = 1'b0;
   logic       odd_f  = 1'b0;
   int         bit_ns = 250;
   logic [7:0] rxq[$];

   // line idles at mark
   initial line_rxd = 1'b1;

   // frame out, lsb first, parity optionally spoiled
   task automatic send(input logic [6:0] c, input logic bad);
      logic [10:0] f;
      f = {2'b11, (^c) ^ odd_f ^ bad, c, 1'b0};
      #3;
      for (int i = 0; i < (long_f ? 11 : 10); i++) begin
         line_rxd = f[i];
         #(bit_ns);
      end
   endtask : send

   // frame in: flag bad parity or a low stop
   always begin : rx_proc
      logic [6:0] c;
      logic       p;
      @(negedge line_txd);
      #(bit_ns * 3 / 2);
      for (int i = 0; i < 7; i++) begin
         c[i] = line_txd;
         #(bit_ns);
      end
      p = line_txd;
      #(bit_ns);
      rxq.push_back({(p ^ (^c) ^ odd_f) | !line_txd, c});
   end
endmodule : tslk_host

// ### tslk_link.sv
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - bit timing from selectable fixed rate list
// - full or half duplex by static setting
// - receiver strips framing, outputs parallel character
// - completed character strobed into double buffer
// - source mux picks keyboard or display logic
// - transmitter frames and shifts character out
// - half duplex loops transmit line into receiver
// - page-buffered keyboard goes local, not line
// - page-buffered line output only after command
// - send command streams whole memory in order
// - page-buffered receiver accepts line anytime
// - page and roll send keystrokes immediately
// - duplex decides keystroke echo to display
// - roll mode limits cursor to bottom
// - characters serial least significant bit first
// - ten or eleven bit frames, even/odd parity
// - display path drops received parity bit
module tslk_link
   import tslk_pkg::*;
#(
   parameter int CLK_HZ    = TSLK_CLK_HZ,
   parameter int MEM_DEPTH = MEM_DEPTH_DEF,
   parameter int AW        = $clog2(MEM_DEPTH)
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // serial line
   input  wire logic              line_rxd,
   output logic                   line_txd,
   // keyboard source
   input  wire logic [CHAR_W-1:0] kbd_char,
   input  wire logic              kbd_valid,
   output logic                   kbd_ready,
   // display control source
   input  wire logic [CHAR_W-1:0] dsp_tx_char,
   input  wire logic              dsp_tx_valid,
   output logic                   dsp_tx_ready,
   // display control sink
   output logic      [CHAR_W-1:0] dsp_rx_char,
   output logic                   dsp_rx_valid,
   input  wire logic              dsp_rx_ready,
   // character memory read port, data one cycle after mem_rd
   output logic      [AW-1:0]     mem_addr,
   output logic                   mem_rd,
   input  wire logic [CHAR_W-1:0] mem_data,
   // cursor control
   output logic                   cursor_bottom_only
);

   typedef struct packed {
      // configuration and sticky status
      logic                half;
      tslk_mode_type       mode;
      logic                flong;
      logic                odd;
      logic [3:0]          baud;
      logic                ovr;
      logic                perr;
      logic                ferr;
      logic [CHAR_W:0]     last_rx;
      // bus data phase
      logic                bus_wr;
      logic [7:0]          bus_addr;
      logic [31:0]         rdata;
      // receiver
      tslk_rx_type         rx;
      logic [BIT_W-1:0]    rcnt;
      logic [2:0]          rbit;
      logic [CHAR_W-1:0]   rsh;
      logic                rpar_bad;
      // double buffer
      logic                a_full;
      logic [CHAR_W-1:0]   a_char;
      logic                b_full;
      logic [CHAR_W-1:0]   b_char;
      // page send
      tslk_ps_type         ps;
      logic [AW-1:0]       ps_addr;
      logic [CHAR_W-1:0]   ps_char;
   } tslk_state_type;

   tslk_state_type    s_r, s_nxt;
   logic [BIT_W-1:0]  bit_cycles;
   logic              rx_in;
   logic              tx_ser;
   logic              tx_ready;
   logic              tx_load;
   logic [CHAR_W-1:0] tx_char;
   logic              pbuf;
   logic              ps_busy;
   logic              kbd_line_go;
   logic              kbd_local_go;
   logic              dsp_go;
   logic              rx_done;
   logic [8:0]        ctrl_val;
   logic [31:0]       stat_val;

   ////////////////////////////////////////////////////////////////////////////////
   // rate, routing and source selection
   assign bit_cycles = tslk_bit_cycles(CLK_HZ, s_r.baud);
   assign pbuf       = (s_r.mode == MODE_PBUF);
   assign ps_busy    = (s_r.ps != PS_IDLE);
   // idle-high lines, so an and merges the local loop into the line input
   assign rx_in      = s_r.half ? (line_rxd & tx_ser) : line_rxd;
   assign line_txd   = tx_ser;
   assign cursor_bottom_only = (s_r.mode == MODE_ROLL);

   // page send owns the transmitter; no display source in page-buffered mode
   assign dsp_go       = !ps_busy && !pbuf && dsp_tx_valid && tx_ready;
   assign kbd_line_go  = !ps_busy && !pbuf && !dsp_tx_valid && kbd_valid && tx_ready;
   assign kbd_local_go = pbuf && kbd_valid && !s_r.a_full && !rx_done;
   assign dsp_tx_ready = dsp_go;
   assign kbd_ready    = kbd_line_go || kbd_local_go;
   assign tx_load      = (s_r.ps == PS_LOAD && tx_ready) || dsp_go || kbd_line_go;
   assign tx_char      = (s_r.ps == PS_LOAD) ? s_r.ps_char :
                         dsp_go ? dsp_tx_char : kbd_char;

   assign mem_addr = s_r.ps_addr;
   assign mem_rd   = (s_r.ps == PS_READ);

   // receiver ends on the first stop sample
   assign rx_done = (s_r.rx == RX_STOP) && (s_r.rcnt == BIT_W'(1));

   assign ctrl_val = {s_r.baud, s_r.odd, s_r.flong, s_r.mode, s_r.half};
   assign stat_val = {26'h0, s_r.ferr, s_r.perr, s_r.ovr, ps_busy, !tx_ready, s_r.b_full};

   ////////////////////////////////////////////////////////////////////////////////
   // transmitter
   tslk_tx u_tx (
      .clk        (clk),
      .rst_n      (rst_n),
      .bit_cycles (bit_cycles),
      .frame_long (s_r.flong),
      .parity_odd (s_r.odd),
      .load       (tx_load),
      .data       (tx_char),
      .ready      (tx_ready),
      .ser        (tx_ser)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;

      // ahb: registered read data, write in the data phase
      if (s_r.bus_wr) begin
         case (s_r.bus_addr)
            OFS_CTRL: begin
               // static settings; changing them mid-character corrupts that character
               s_nxt.half  = hwdata[CTRL_HALF_BIT];
               s_nxt.mode  = tslk_mode_type'(hwdata[CTRL_MODE_LSB +: 2]);
               s_nxt.flong = hwdata[CTRL_LONG_BIT];
               s_nxt.odd   = hwdata[CTRL_ODD_BIT];
               s_nxt.baud  = hwdata[CTRL_BAUD_LSB +: 4];
            end
            OFS_CMD: begin
               // a send command outside page-buffered mode or while sending is ignored
               if (hwdata[CMD_SEND_BIT] && pbuf && !ps_busy) begin
                  s_nxt.ps      = PS_READ;
                  s_nxt.ps_addr = '0;
               end
            end
            OFS_STATUS: begin
               s_nxt.ovr  = s_r.ovr  & ~hwdata[ST_OVR_BIT];
               s_nxt.perr = s_r.perr & ~hwdata[ST_PERR_BIT];
               s_nxt.ferr = s_r.ferr & ~hwdata[ST_FERR_BIT];
            end
            default: begin
            end
         endcase
      end
      s_nxt.bus_wr = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_nxt.bus_wr   = hwrite;
         s_nxt.bus_addr = haddr[7:0];
         if (!hwrite) begin
            case (haddr[7:0])
               OFS_CTRL:   s_nxt.rdata = {23'h0, ctrl_val};
               OFS_STATUS: s_nxt.rdata = stat_val;
               OFS_LASTRX: s_nxt.rdata = {24'h0, s_r.last_rx};
               default:    s_nxt.rdata = 32'h0;
            endcase
         end
      end

      // receiver: centre sampling, lsb first
      case (s_r.rx)
         RX_IDLE: begin
            if (!rx_in) begin
               s_nxt.rx   = RX_START;
               s_nxt.rcnt = {1'b0, bit_cycles[BIT_W-1:1]};
            end
         end
         RX_START: begin
            if (s_r.rcnt > BIT_W'(1)) begin
               s_nxt.rcnt = s_r.rcnt - BIT_W'(1);
            end else if (!rx_in) begin
               s_nxt.rx   = RX_DATA;
               s_nxt.rcnt = bit_cycles;
               s_nxt.rbit = 3'h0;
            end else begin
               s_nxt.rx = RX_IDLE; // glitch shorter than half a bit
            end
         end
         RX_DATA: begin
            if (s_r.rcnt > BIT_W'(1)) begin
               s_nxt.rcnt = s_r.rcnt - BIT_W'(1);
            end else begin
               s_nxt.rcnt = bit_cycles;
               s_nxt.rsh  = {rx_in, s_r.rsh[CHAR_W-1:1]};
               s_nxt.rbit = s_r.rbit + 3'h1;
               if (s_r.rbit == 3'(CHAR_W - 1)) begin
                  s_nxt.rx = RX_PAR;
               end
            end
         end
         RX_PAR: begin
            if (s_r.rcnt > BIT_W'(1)) begin
               s_nxt.rcnt = s_r.rcnt - BIT_W'(1);
            end else begin
               s_nxt.rcnt     = bit_cycles;
               s_nxt.rpar_bad = (^s_r.rsh ^ rx_in) != s_r.odd;
               s_nxt.rx       = RX_STOP;
            end
         end
         RX_STOP: begin
            // a second stop bit simply reads as idle line
            if (s_r.rcnt > BIT_W'(1)) begin
               s_nxt.rcnt = s_r.rcnt - BIT_W'(1);
            end else begin
               s_nxt.rx      = RX_IDLE;
               s_nxt.last_rx = {s_r.rpar_bad, s_r.rsh};
            end
         end
         default: s_nxt.rx = RX_IDLE;
      endcase

      // double buffer: stage b faces the display, stage a catches the next character
      if (s_r.b_full && dsp_rx_ready) begin
         s_nxt.b_full = 1'b0;
      end
      if (s_r.a_full && (!s_r.b_full || dsp_rx_ready)) begin
         s_nxt.b_full = 1'b1;
         s_nxt.b_char = s_r.a_char;
         s_nxt.a_full = 1'b0;
      end
      if (rx_done) begin
         if (!s_nxt.a_full) begin
            s_nxt.a_full = 1'b1;
            s_nxt.a_char = s_r.rsh;
         end else begin
            s_nxt.ovr = 1'b1;
         end
         if (s_r.rpar_bad) begin
            s_nxt.perr = 1'b1;
         end
         if (!rx_in) begin
            s_nxt.ferr = 1'b1;
         end
      end else if (kbd_local_go) begin
         s_nxt.a_full = 1'b1;
         s_nxt.a_char = kbd_char;
      end

      // page send: each memory cell in order to the transmitter
      case (s_r.ps)
         PS_IDLE: begin
         end
         PS_READ: s_nxt.ps = PS_WAIT;
         PS_WAIT: begin
            s_nxt.ps_char = mem_data;
            s_nxt.ps      = PS_LOAD;
         end
         PS_LOAD: begin
            if (tx_ready) begin
               if (s_r.ps_addr == AW'(MEM_DEPTH - 1)) begin
                  s_nxt.ps = PS_IDLE;
               end else begin
                  s_nxt.ps_addr = s_r.ps_addr + AW'(1);
                  s_nxt.ps      = PS_READ;
               end
            end
         end
         default: s_nxt.ps = PS_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r          <= '0;
         {s_r.baud, s_r.odd, s_r.flong, s_r.mode, s_r.half} <= CTRL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs; the echo to display in page and roll relies on the half-duplex loop
   assign dsp_rx_char  = s_r.b_char;
   assign dsp_rx_valid = s_r.b_full;
   assign hrdata       = s_r.rdata;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;

endmodule : tslk_link

// ### tslk_link_checker.sv
`timescale 1ns/1ps
module tslk_link_checker
   import tslk_pkg::*;
#(
   parameter int CLK_HZ    = TSLK_CLK_HZ,
   parameter int MEM_DEPTH = MEM_DEPTH_DEF,
   parameter int AW        = $clog2(MEM_DEPTH)
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              rst_n,
   // bus
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   // line and sources
   input wire logic              line_txd,
   input wire logic [CHAR_W-1:0] kbd_char,
   input wire logic              kbd_valid,
   input wire logic              kbd_ready,
   input wire logic [CHAR_W-1:0] dsp_tx_char,
   input wire logic              dsp_tx_valid,
   input wire logic              dsp_tx_ready,
   // display sink, memory, cursor
   input wire logic [CHAR_W-1:0] dsp_rx_char,
   input wire logic              dsp_rx_valid,
   input wire logic              dsp_rx_ready,
   input wire logic [AW-1:0]     mem_addr,
   input wire logic              mem_rd,
   input wire logic              cursor_bottom_only
);
   localparam int BITC = CLK_HZ / 4800;
   localparam int MID0 = BITC + BITC / 2 - 1;
   localparam int MIDP = 8 * BITC + BITC / 2 - 1;
   localparam int MIDS = 9 * BITC + BITC / 2 - 1;

   logic              wph_r;
   logic [7:0]        wad_r;
   logic [8:0]        ctl_r;
   logic [CHAR_W-1:0] ld_r;
   logic              txd_d_r;
   logic [19:0]       cnt_r;
   logic [AW-1:0]     ea_r;
   logic [1:0]        mode;
   logic              tx_chk;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // control shadow, last load, frame clock count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wph_r   <= 1'b0;
         wad_r   <= 8'h00;
         ctl_r   <= CTRL_RESET;
         ld_r    <= '0;
         txd_d_r <= 1'b1;
         cnt_r   <= 20'hfffff;
         ea_r    <= '0;
      end else begin
         wph_r   <= hsel && hready && htrans[1] && hwrite;
         wad_r   <= haddr[7:0];
         txd_d_r <= line_txd;
         if (wph_r && hready && wad_r == OFS_CTRL) ctl_r <= hwdata[8:0];
         if (dsp_tx_valid && dsp_tx_ready) ld_r <= dsp_tx_char;
         else if (kbd_valid && kbd_ready) ld_r <= kbd_char;
         // only a fall after a whole frame restarts the count
         if (txd_d_r && !line_txd && cnt_r >= 20'(10 * BITC)) cnt_r <= '0;
         else if (cnt_r != 20'hfffff) cnt_r <= cnt_r + 20'h1;
         if (mem_rd) ea_r <= (ea_r == AW'(MEM_DEPTH - 1)) ? '0 : ea_r + 1'b1;
      end
   end

   assign mode   = ctl_r[2:1];
   // page send loads bypass ld_r, so bit checks skip that mode; they also run at rate selector 8 only
   assign tx_chk = ctl_r[8:5] == 4'h8 && mode != MODE_PBUF;

   ////////////////////////////////////////////////////////////////////////////////
   a_pbuf_no_disp: assert property (mode == MODE_PBUF |-> !dsp_tx_ready)
      else $error("display taken in page-buffered mode");
   a_kbd_start: assert property (mode != MODE_PBUF && kbd_valid && kbd_ready |=> !line_txd [*8])
      else $error("no start bit after keystroke");
   a_bit0_lsb: assert property (tx_chk && cnt_r == 20'(MID0) |-> line_txd == ld_r[0])
      else $error("first data bit not lsb");
   a_parity_bit: assert property (tx_chk && cnt_r == 20'(MIDP) |-> line_txd == (^ld_r ^ ctl_r[4]))
      else $error("parity bit wrong");
   a_stop_bit: assert property (tx_chk && cnt_r == 20'(MIDS) |-> line_txd)
      else $error("stop bit low");
   a_rx_hold: assert property (dsp_rx_valid && !dsp_rx_ready |=> dsp_rx_valid && $stable(dsp_rx_char))
      else $error("display char not held");
   a_cursor_mode: assert property ($stable(mode) |-> cursor_bottom_only == (mode == MODE_ROLL))
      else $error("cursor does not follow mode");
   a_mem_order: assert property (mem_rd |-> mem_addr == ea_r)
      else $error("memory read out of order");
   a_pbuf_local: assert property (mode == MODE_PBUF && kbd_valid && kbd_ready |-> ##[1:3] dsp_rx_valid)
      else $error("keystroke not shown locally");
endmodule : tslk_link_checker

bind tslk_link tslk_link_checker #(.CLK_HZ(CLK_HZ), .MEM_DEPTH(MEM_DEPTH), .AW(AW)) u_chk (
   .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .line_txd(line_txd), .kbd_char(kbd_char),
   .kbd_valid(kbd_valid), .kbd_ready(kbd_ready), .dsp_tx_char(dsp_tx_char),
   .dsp_tx_valid(dsp_tx_valid), .dsp_tx_ready(dsp_tx_ready), .dsp_rx_char(dsp_rx_char),
   .dsp_rx_valid(dsp_rx_valid), .dsp_rx_ready(dsp_rx_ready), .mem_addr(mem_addr),
   .mem_rd(mem_rd), .cursor_bottom_only(cursor_bottom_only));

// ### tslk_pkg.sv
package tslk_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and line timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int TSLK_CLK_HZ   = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int BAUD_N        = 9;
   localparam int BAUD_TABLE [BAUD_N] = '{110, 150, 300, 600, 1200, 1800, 2400, 3600, 4800};
   localparam int BIT_W         = 19;   // holds one bit time at the slowest rate
   localparam int CHAR_W        = 7;
   localparam int FRAME_SHORT   = 10;
   localparam int FRAME_LONG    = 11;
   localparam int MEM_DEPTH_DEF = 1920;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CMD    = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_LASTRX = 8'h0c;

   // control register fields
   localparam int CTRL_HALF_BIT  = 0;
   localparam int CTRL_MODE_LSB  = 1;
   localparam int CTRL_LONG_BIT  = 3;
   localparam int CTRL_ODD_BIT   = 4;
   localparam int CTRL_BAUD_LSB  = 5;
   localparam logic [8:0] CTRL_RESET = 9'h000;

   // command and status fields
   localparam int CMD_SEND_BIT    = 0;
   localparam int ST_OUTVAL_BIT   = 0;
   localparam int ST_TXBUSY_BIT   = 1;
   localparam int ST_SENDING_BIT  = 2;
   localparam int ST_OVR_BIT      = 3;
   localparam int ST_PERR_BIT     = 4;
   localparam int ST_FERR_BIT     = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // modes and states
   typedef enum logic [1:0] {
      MODE_PAGE = 2'b00,
      MODE_ROLL = 2'b01,
      MODE_PBUF = 2'b10
   } tslk_mode_type;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } tslk_rx_type;

   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_READ = 2'b01,
      PS_WAIT = 2'b10,
      PS_LOAD = 2'b11
   } tslk_ps_type;

   // bit time in clocks for a rate selector; selectors above the table use the top rate
   function automatic logic [BIT_W-1:0] tslk_bit_cycles(input int clk_hz,
                                                        input logic [3:0] sel);
      int i;
      i = (sel > 4'h8) ? 8 : int'(sel);
      return BIT_W'(clk_hz / BAUD_TABLE[i]);
   endfunction : tslk_bit_cycles

endpackage : tslk_pkg

// ### tslk_tx.sv
`timescale 1ns/1ps
module tslk_tx
   import tslk_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // format
   input  wire logic [BIT_W-1:0]  bit_cycles,
   input  wire logic              frame_long,
   input  wire logic              parity_odd,
   // parallel load
   input  wire logic              load,
   input  wire logic [CHAR_W-1:0] data,
   output logic                   ready,
   // serial out, idle high
   output logic                   ser
);

   typedef struct packed {
      logic             busy;
      logic [BIT_W-1:0] cnt;
      logic [10:0]      sh;
      logic [3:0]       left;
   } tslk_tx_state_type;

   tslk_tx_state_type s_r, s_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // framing and shifting
   always_comb begin
      s_nxt = s_r;
      if (!s_r.busy) begin
         if (load) begin
            // start, data lsb first, parity, stops from the fill
            s_nxt.sh   = {2'b11, (^data) ^ parity_odd, data, 1'b0};
            s_nxt.left = frame_long ? 4'(FRAME_LONG) : 4'(FRAME_SHORT);
            s_nxt.cnt  = bit_cycles;
            s_nxt.busy = 1'b1;
         end
      end else if (s_r.cnt > BIT_W'(1)) begin
         s_nxt.cnt = s_r.cnt - BIT_W'(1);
      end else begin
         s_nxt.cnt  = bit_cycles;
         s_nxt.sh   = {1'b1, s_r.sh[10:1]};
         s_nxt.left = s_r.left - 4'h1;
         if (s_r.left == 4'h1) begin
            s_nxt.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '{busy: 1'b0, cnt: '0, sh: 11'h7ff, left: 4'h0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ready = !s_r.busy;
   assign ser   = s_r.busy ? s_r.sh[0] : 1'b1;

endmodule : tslk_tx
